// file: logic/psl_params.svh
`ifndef PSL_PARAMS_SVH
`define PSL_PARAMS_SVH

// Register byte offsets on the AHB-Lite port, decoded on haddr[7:0].
`define PSL_ADDR_LSB_W    8
`define PSL_OFF_STRAP     8'h00
`define PSL_OFF_CFG       8'h04
`define PSL_OFF_MODE      8'h08
`define PSL_OFF_PRESET    8'h0c

// Read word padding widths.
`define PSL_STRAP_PAD_W   12
`define PSL_CFG_PAD_W     20
`define PSL_MODE_PAD_W    16
`define PSL_PRESET_PAD_W  16
`define PSL_FLAG_PAD_W    1

// Reset values.
`define PSL_CFG_RST       12'h000
`define PSL_STRAP_RST     20'h00000
`define PSL_COUNT_RST     8'h00
`define PSL_PRESET_RST    16'h0000
`define PSL_FLAGS_RST     7'h00
`define PSL_RDATA_RST     32'h00000000
`define PSL_SYNC_RST      1'b0

// Register preset words selected by the jack preset strap.
`define PSL_PRESET_NORMAL 16'h0000
`define PSL_PRESET_JACK   16'h0001

// Device mode codes and group codes on mode[4:3].
`define PSL_MODE_NAND     5'h04
`define PSL_MODE_DEV_PD   5'h07
`define PSL_MODE_SWPD_ON  5'h08
`define PSL_MODE_SWPD_OFF 5'h09
`define PSL_GRP_TEST      2'h0
`define PSL_GRP_FORCED    2'h1

// AHB transfer type bit that marks NONSEQ or SEQ.
`define PSL_HTRANS_ACT    1

`endif

// file: logic/psl_pkg.sv
package psl_pkg;

  typedef struct packed {
    logic       jack_preset_strap;
    logic       refclk_out_enable;
    logic       rgmii_sel;
    logic [4:0] mode;
    logic       indicator_style_strap;
    logic [4:0] indicator_strap;
    logic       broadcast_addr_strap;
    logic [4:0] mgmt_addr_strap;
  } psl_strap_t;

  typedef struct packed {
    logic       indicator_individual;
    logic [4:0] indicator_polarity;
    logic       broadcast_en;
    logic [4:0] mgmt_addr;
  } psl_cfg_t;

  typedef struct packed {
    logic autoneg_mode;
    logic forced_mode;
    logic test_mode;
    logic swpd_pll_off;
    logic swpd_pll_on;
    logic dev_power_down;
    logic nand_tree;
  } psl_mode_flags_t;

  typedef enum logic {
    PSL_WAIT,
    PSL_RUN
  } psl_state_t;

endpackage

// file: logic/psl_sync2.sv
`timescale 1ns/1ps
`include "psl_params.svh"

module psl_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      meta_r   <= {W{`PSL_SYNC_RST}};
      sync_out <= {W{`PSL_SYNC_RST}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // psl_sync2

// file: logic/psl_mode_dec.sv
`timescale 1ns/1ps
`include "psl_params.svh"

module psl_mode_dec (
  // Captured device mode field.
  input  wire logic [4:0]              mode_in,
  // Decoded mode flags.
  output psl_pkg::psl_mode_flags_t     flags_out
);

  import psl_pkg::*;

  wire [1:0] group_w = mode_in[4:3];

  assign flags_out.nand_tree      = (mode_in == `PSL_MODE_NAND);
  assign flags_out.dev_power_down = (mode_in == `PSL_MODE_DEV_PD);
  assign flags_out.swpd_pll_on    = (mode_in == `PSL_MODE_SWPD_ON);
  assign flags_out.swpd_pll_off   = (mode_in == `PSL_MODE_SWPD_OFF);
  assign flags_out.test_mode      = (group_w == `PSL_GRP_TEST);
  assign flags_out.forced_mode    = (group_w == `PSL_GRP_FORCED)
                                    && !flags_out.swpd_pll_on
                                    && !flags_out.swpd_pll_off;
  assign flags_out.autoneg_mode   = mode_in[4];

endmodule // psl_mode_dec

// file: logic/psl_strap_latch.sv
`timescale 1ns/1ps
`include "psl_params.svh"

module psl_strap_latch (
  // Clock and synchronous reset.
  input  wire logic                      core_clk_in,
  input  wire logic                      rst_n_in,
  // Chip reset pin and strap pins.
  input  wire logic                      chip_rst_n_in,
  input  wire psl_pkg::psl_strap_t       strap_pins_in,
  // AHB-Lite slave.
  input  wire logic                      hsel_in,
  input  wire logic [31:0]               haddr_in,
  input  wire logic [1:0]                htrans_in,
  input  wire logic                      hwrite_in,
  input  wire logic [2:0]                hsize_in,
  input  wire logic [31:0]               hwdata_in,
  input  wire logic                      hready_in,
  output logic                           hreadyout_out,
  output logic                           hresp_out,
  output logic [31:0]                    hrdata_out,
  // Configuration outputs.
  output psl_pkg::psl_strap_t            strap_out,
  output psl_pkg::psl_cfg_t              cfg_out,
  output psl_pkg::psl_mode_flags_t       mode_flags_out,
  output logic [15:0]                    preset_word_out,
  output logic                           rgmii_sel_out,
  output logic                           refclk_out_enable_out,
  output logic                           cfg_valid_out
);

  import psl_pkg::*;

  psl_strap_t      strap_sync;
  logic            chip_run_sync;
  psl_state_t      st_r;
  psl_state_t      st_nxt;
  logic [7:0]      cap_count_r;
  psl_mode_flags_t dec_flags;

  // Pins pass two flip-flops in the same pipeline, so strap and reset line up.
  psl_sync2 #(.W($bits(psl_strap_t))) u_strap_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .async_in    (strap_pins_in),
    .sync_out    (strap_sync)
  );

  psl_sync2 #(.W(1)) u_rst_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .async_in    (chip_rst_n_in),
    .sync_out    (chip_run_sync)
  );

  // Capture happens once per release, on the first cycle the chip reset is seen released.
  wire capture_w = (st_r == PSL_WAIT) && chip_run_sync;

  always_comb begin
    unique case (st_r)
      PSL_WAIT: st_nxt = chip_run_sync ? PSL_RUN : PSL_WAIT;
      PSL_RUN:  st_nxt = chip_run_sync ? PSL_RUN : PSL_WAIT;
    endcase
  end

  // Working configuration loaded from the straps.
  psl_cfg_t cap_cfg_w;
  assign cap_cfg_w.mgmt_addr            = strap_sync.mgmt_addr_strap;
  assign cap_cfg_w.broadcast_en         = ~strap_sync.broadcast_addr_strap;
  assign cap_cfg_w.indicator_polarity   = ~strap_sync.indicator_strap;
  assign cap_cfg_w.indicator_individual = strap_sync.indicator_style_strap;

  wire [15:0] cap_preset_w = strap_sync.jack_preset_strap ? `PSL_PRESET_JACK
                                                          : `PSL_PRESET_NORMAL;

  psl_mode_dec u_mode_dec (
    .mode_in   (strap_out.mode),
    .flags_out (dec_flags)
  );

  // AHB-Lite address phase decode.
  wire                      bus_sel_w = hsel_in && hready_in
                                        && htrans_in[`PSL_HTRANS_ACT];
  wire [`PSL_ADDR_LSB_W-1:0] addr_w   = haddr_in[`PSL_ADDR_LSB_W-1:0];
  wire                      rd_sel_w  = bus_sel_w && !hwrite_in;
  wire                      wr_sel_w  = bus_sel_w && hwrite_in;
  wire                      hit_strap = (addr_w == `PSL_OFF_STRAP);
  wire                      hit_cfg   = (addr_w == `PSL_OFF_CFG);
  wire                      hit_mode  = (addr_w == `PSL_OFF_MODE);
  wire                      hit_pre   = (addr_w == `PSL_OFF_PRESET);

  logic wr_cfg_pend_r;

  // Software writes to the configuration land in the data phase.
  psl_cfg_t wr_cfg_w;
  assign wr_cfg_w = hwdata_in[$bits(psl_cfg_t)-1:0];
  wire      wr_cfg_do_w = wr_cfg_pend_r && !capture_w;

  psl_cfg_t cfg_view_w;
  assign cfg_view_w = wr_cfg_pend_r ? wr_cfg_w : cfg_out;

  wire [31:0] rd_strap_w = {{`PSL_STRAP_PAD_W{1'b0}}, strap_out};
  wire [31:0] rd_cfg_w   = {{`PSL_CFG_PAD_W{1'b0}}, cfg_view_w};
  wire [31:0] rd_mode_w  = {{`PSL_MODE_PAD_W{1'b0}}, cap_count_r,
                            {`PSL_FLAG_PAD_W{1'b0}}, mode_flags_out};
  wire [31:0] rd_pre_w   = {{`PSL_PRESET_PAD_W{1'b0}}, preset_word_out};
  wire [31:0] rd_word_w  = hit_strap ? rd_strap_w :
                           hit_cfg   ? rd_cfg_w   :
                           hit_mode  ? rd_mode_w  :
                           hit_pre   ? rd_pre_w   : `PSL_RDATA_RST;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_r <= PSL_WAIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Captured straps change only at a capture.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      strap_out             <= `PSL_STRAP_RST;
      preset_word_out       <= `PSL_PRESET_RST;
      rgmii_sel_out         <= 1'b0;
      refclk_out_enable_out <= 1'b0;
      cap_count_r           <= `PSL_COUNT_RST;
    end else if (capture_w) begin
      strap_out             <= strap_sync;
      preset_word_out       <= cap_preset_w;
      rgmii_sel_out         <= strap_sync.rgmii_sel;
      refclk_out_enable_out <= strap_sync.refclk_out_enable;
      cap_count_r           <= cap_count_r + 8'h01;
    end
  end

  // Capture wins over a software write landing in the same cycle.
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cfg_out <= `PSL_CFG_RST;
    end else if (capture_w) begin
      cfg_out <= cap_cfg_w;
    end else if (wr_cfg_do_w) begin
      cfg_out <= wr_cfg_w;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mode_flags_out <= `PSL_FLAGS_RST;
      cfg_valid_out  <= 1'b0;
    end else begin
      mode_flags_out <= dec_flags;
      cfg_valid_out  <= (st_r == PSL_RUN) && chip_run_sync;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      wr_cfg_pend_r <= 1'b0;
      hrdata_out    <= `PSL_RDATA_RST;
      hreadyout_out <= 1'b0;
      hresp_out     <= 1'b0;
    end else begin
      wr_cfg_pend_r <= wr_sel_w && hit_cfg;
      hrdata_out    <= rd_sel_w ? rd_word_w : `PSL_RDATA_RST;
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Capture and hold checks.
  chk_capture_on_release: assert property (
    capture_w |=> (strap_out == $past(strap_sync)) && (st_r == PSL_RUN))
    else $error("straps not captured at reset release");

  chk_single_capture: assert property (
    capture_w |=> !capture_w)
    else $error("straps captured twice for one release");

  chk_wait_quiet: assert property (
    (st_r == PSL_WAIT) && !chip_run_sync |=> $stable(strap_out) && $stable(preset_word_out))
    else $error("captured values moved while chip reset held");

  chk_valid_in_run: assert property (
    cfg_valid_out |-> (st_r == PSL_RUN))
    else $error("configuration valid outside run state");

  chk_valid_drop: assert property (
    !chip_run_sync |=> !cfg_valid_out)
    else $error("configuration valid while chip reset held");

  chk_strap_hold: assert property (
    (st_r == PSL_RUN) ##1 (st_r == PSL_RUN) |-> $stable(strap_out))
    else $error("captured straps changed without a new release");

  chk_pins_ignored: assert property (
    (st_r == PSL_RUN) && (strap_sync != strap_out) |=> $stable(strap_out))
    else $error("strap pin change leaked into captured straps");

  chk_outputs_hold: assert property (
    (st_r == PSL_RUN) |=> $stable(preset_word_out) && $stable(rgmii_sel_out)
                          && $stable(refclk_out_enable_out))
    else $error("captured outputs changed while running");

  chk_cfg_hold: assert property (
    (st_r == PSL_RUN) && !wr_cfg_do_w |=> $stable(cfg_out))
    else $error("configuration changed without capture or write");

  chk_preset_select: assert property (
    capture_w |=> preset_word_out == (strap_out.jack_preset_strap ? `PSL_PRESET_JACK
                                                                  : `PSL_PRESET_NORMAL))
    else $error("preset word does not follow jack strap");

  chk_addr_direct: assert property (
    capture_w |=> cfg_out.mgmt_addr == $past(strap_sync.mgmt_addr_strap))
    else $error("management address differs from strap levels");

  chk_led_polarity: assert property (
    capture_w |=> cfg_out.indicator_polarity == ~$past(strap_sync.indicator_strap))
    else $error("indicator polarity not inverse of strap");

  chk_bcast_invert: assert property (
    capture_w |=> cfg_out.broadcast_en == !$past(strap_sync.broadcast_addr_strap))
    else $error("broadcast enable not inverse of strap");

  chk_bcast_answer: assert property (
    capture_w |=> cfg_out.broadcast_en != strap_out.broadcast_addr_strap)
    else $error("broadcast answering does not follow strap");

  chk_style_rgmii: assert property (
    capture_w |=> (cfg_out.indicator_individual == strap_out.indicator_style_strap)
                  && (rgmii_sel_out == strap_out.rgmii_sel))
    else $error("indicator style or interface select wrong");

  chk_rgmii_capture: assert property (
    capture_w |=> rgmii_sel_out == $past(strap_sync.rgmii_sel))
    else $error("interface select not taken from strap");

  chk_refclk_enable: assert property (
    (st_r == PSL_RUN) |-> refclk_out_enable_out == strap_out.refclk_out_enable)
    else $error("reference clock enable differs from strap");

  chk_refclk_capture: assert property (
    capture_w |=> refclk_out_enable_out == $past(strap_sync.refclk_out_enable))
    else $error("reference clock enable not taken from strap");

  // Mode decode checks.
  chk_mode_capture: assert property (
    capture_w |=> strap_out.mode == $past(strap_sync.mode))
    else $error("device mode not taken from straps");

  chk_mode_nand: assert property (
    (strap_out.mode == `PSL_MODE_NAND) |=> mode_flags_out.nand_tree
                                           && !mode_flags_out.dev_power_down)
    else $error("NAND tree mode not decoded");

  chk_mode_devpd: assert property (
    (strap_out.mode == `PSL_MODE_DEV_PD) |=> mode_flags_out.dev_power_down
                                             && !mode_flags_out.nand_tree)
    else $error("device power down mode not decoded");

  chk_mode_swpd_on: assert property (
    (strap_out.mode == `PSL_MODE_SWPD_ON) |=> mode_flags_out.swpd_pll_on
                                              && !mode_flags_out.swpd_pll_off)
    else $error("soft power down with clock running not decoded");

  chk_mode_swpd: assert property (
    (strap_out.mode == `PSL_MODE_SWPD_OFF) |=> mode_flags_out.swpd_pll_off
                                               && !mode_flags_out.swpd_pll_on)
    else $error("soft power down mode not decoded");

  // Register bus checks.
  chk_bus_okay: assert property (
    $past(rst_n_in) |-> hreadyout_out && !hresp_out)
    else $error("bus slave not ready or not okay");

  chk_cfg_write: assert property (
    wr_cfg_do_w |=> cfg_out == $past(wr_cfg_w))
    else $error("configuration write did not land");

  chk_read_idle: assert property (
    !rd_sel_w |=> hrdata_out == `PSL_RDATA_RST)
    else $error("read data not cleared outside a read");

  chk_read_strap: assert property (
    rd_sel_w && hit_strap && !capture_w |=> hrdata_out == {{`PSL_STRAP_PAD_W{1'b0}},
                                                           $past(strap_out)})
    else $error("strap register read wrong");

  cov_capture: cover property (capture_w ##1 (st_r == PSL_RUN));
  cov_cfg_write: cover property (wr_cfg_do_w);
  cov_recapture: cover property (capture_w && (cap_count_r != `PSL_COUNT_RST));
  cov_jack_preset: cover property (capture_w && strap_sync.jack_preset_strap);
  cov_swpd_mode: cover property (mode_flags_out.swpd_pll_off);

endmodule // psl_strap_latch

// file: verification/psl_board_model.sv
`timescale 1ns/1ps

module psl_board_model (
  // Clock.
  input  wire logic          core_clk_in,
  // Chip reset and strap pins.
  output logic               chip_rst_n_out,
  output psl_pkg::psl_strap_t strap_pins_out
);
  import psl_pkg::*;

  initial begin
    chip_rst_n_out = 1'b0;
    strap_pins_out = '0;
  end

  task automatic hold_reset();
    @(posedge core_clk_in);
    chip_rst_n_out <= 1'b0;
  endtask

  // After the hold time the shared pins turn into indicator outputs and move.
  task automatic release_with(input psl_strap_t v);
    @(posedge core_clk_in);
    strap_pins_out <= v;
    repeat (4) @(posedge core_clk_in);
    chip_rst_n_out <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    strap_pins_out <= ~v;
  endtask
endmodule // psl_board_model

// file: verification/psl_strap_latch_bench.sv
`timescale 1ns/1ps
`include "psl_params.svh"

module psl_strap_latch_bench;
  import psl_pkg::*;

  logic            core_clk_in = 1'b0;
  logic            rst_n_in    = 1'b0;
  logic            chip_rst_n;
  psl_strap_t      pins;
  logic            hsel   = 1'b0;
  logic [31:0]     haddr  = 32'h00000000;
  logic [1:0]      htrans = 2'h0;
  logic            hwrite = 1'b0;
  logic [31:0]     hwdata = 32'h00000000;
  logic            hreadyout;
  logic            hresp;
  logic [31:0]     hrdata;
  psl_strap_t      strap;
  psl_cfg_t        cfg;
  psl_mode_flags_t flags;
  logic [15:0]     preset;
  logic            rgmii;
  logic            refclk;
  logic            cfg_valid;
  int              fails        = 0;
  int              total_checks = 0;
  logic [19:0]     vecs [6]     = '{20'h04000, 20'he7fff, 20'h08295, 20'h8956a,
                                    20'h4a001, 20'h30800};

  always #4 core_clk_in = ~core_clk_in;

  psl_board_model board (
    .core_clk_in    (core_clk_in),
    .chip_rst_n_out (chip_rst_n),
    .strap_pins_out (pins)
  );

  psl_strap_latch uut (
    .core_clk_in           (core_clk_in),
    .rst_n_in              (rst_n_in),
    .chip_rst_n_in         (chip_rst_n),
    .strap_pins_in         (pins),
    .hsel_in               (hsel),
    .haddr_in              (haddr),
    .htrans_in             (htrans),
    .hwrite_in             (hwrite),
    .hsize_in              (3'h2),
    .hwdata_in             (hwdata),
    .hready_in             (hreadyout),
    .hreadyout_out         (hreadyout),
    .hresp_out             (hresp),
    .hrdata_out            (hrdata),
    .strap_out             (strap),
    .cfg_out               (cfg),
    .mode_flags_out        (flags),
    .preset_word_out       (preset),
    .rgmii_sel_out         (rgmii),
    .refclk_out_enable_out (refclk),
    .cfg_valid_out         (cfg_valid)
  );

  function automatic psl_cfg_t cfg_of(input psl_strap_t v);
    return '{v.indicator_style_strap, ~v.indicator_strap, ~v.broadcast_addr_strap,
             v.mgmt_addr_strap};
  endfunction

  function automatic psl_mode_flags_t flags_of(input logic [4:0] m);
    return '{m[4], (m[4:3] == 2'h1) && (m != 5'h08) && (m != 5'h09), m[4:3] == 2'h0,
             m == 5'h09, m == 5'h08, m == 5'h07, m == 5'h04};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; called right after a rising edge.
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= addr;
    hwrite <= wr;
    do @(posedge core_clk_in); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk_in); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #50000;
    fails++;
    tally_and_finish();
  end

  initial begin
    psl_strap_t  v;
    psl_strap_t  prev;
    logic [31:0] rd;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    do @(posedge core_clk_in); while (hreadyout !== 1'b1);
    @(posedge core_clk_in);
    for (int i = 0; i < 6; i++) begin
      v = vecs[i];
      prev = strap;
      board.hold_reset();
      repeat (4) @(posedge core_clk_in);
      check(32'(cfg_valid), 32'h0);
      check(32'(strap), 32'(prev));
      board.release_with(v);
      repeat (4) @(posedge core_clk_in);
      check(32'(strap), 32'(v));
      check(32'(cfg), 32'(cfg_of(v)));
      check(32'(rgmii), 32'(v.rgmii_sel));
      check(32'(refclk), 32'(v.refclk_out_enable));
      check(32'(preset), v.jack_preset_strap ? 32'h1 : 32'h0);
      check(32'(flags), 32'(flags_of(v.mode)));
      check(32'(cfg_valid), 32'h1);
      ahb(1'b0, 32'(`PSL_OFF_STRAP), 32'h0, rd);
      check(rd, 32'(v));
      ahb(1'b0, 32'(`PSL_OFF_CFG), 32'h0, rd);
      check(rd, 32'(cfg_of(v)));
      ahb(1'b0, 32'(`PSL_OFF_PRESET), 32'h0, rd);
      check(rd, v.jack_preset_strap ? 32'h1 : 32'h0);
      $display("Capture test %0d done", i);
    end
    ahb(1'b1, 32'(`PSL_OFF_CFG), 32'h000005a5, rd);
    ahb(1'b0, 32'(`PSL_OFF_CFG), 32'h0, rd);
    check(rd, 32'h000005a5);
    check(32'(cfg), 32'h000005a5);
    ahb(1'b1, 32'(`PSL_OFF_STRAP), 32'hffffffff, rd);
    ahb(1'b0, 32'(`PSL_OFF_STRAP), 32'h0, rd);
    check(rd, 32'(v));
    ahb(1'b0, 32'(`PSL_OFF_MODE), 32'h0, rd);
    check(rd, {16'h0000, 8'h06, 1'b0, flags_of(v.mode)});
    ahb(1'b0, 32'h00000010, 32'h0, rd);
    check(rd, 32'h0);
    check(32'(hresp), 32'h0);
    $display("Register bus test done");
    tally_and_finish();
  end
endmodule // psl_strap_latch_bench
